// ---- error_core_model.sv ----
// core-side model raising error events and frame restarts
`timescale 1ns/1ps
module error_core_model (
	// clock
	input  wire logic pclk,
	// error sources toward the manager
	output logic        soft_panic,
	output logic        loop_overrun,
	output logic        stack_overrun,
	output logic [11:0] parity_error,
	output logic [15:0] execute_pc,
	output logic        frame_restart
);
	// ===========================================================
	// execute stage count, back to zero at each frame start
	initial begin
		soft_panic = 1'b0;
		loop_overrun = 1'b0;
		stack_overrun = 1'b0;
		parity_error = 12'h000;
		execute_pc = 16'h0000;
		frame_restart = 1'b0;
	end
	always @(posedge pclk) begin
		execute_pc <= frame_restart ? 16'h0000 : execute_pc + 16'h0001;
	end
	// ===========================================================
	// one-cycle event on each source set in code; pc as sampled
	task automatic fire(input logic [15:0] code, output logic [15:0] pc);
		@(posedge pclk);
		soft_panic <= code[15];
		loop_overrun <= code[14];
		stack_overrun <= code[13];
		parity_error <= code[11:0];
		@(posedge pclk);
		pc = execute_pc;
		soft_panic <= 1'b0;
		loop_overrun <= 1'b0;
		stack_overrun <= 1'b0;
		parity_error <= 12'h000;
	endtask
	task automatic restart();
		@(posedge pclk);
		frame_restart <= 1'b1;
		@(posedge pclk);
		frame_restart <= 1'b0;
	endtask
endmodule

// ---- error_manager.sv ----
// error manager with watchdog, APB register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module error_manager #(
	parameter int unsigned STEP_BASE = error_manager_pkg::STEP_BASE_CYCLES
) (
	// clock and reset
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	// apb slave
	input  wire logic [error_manager_pkg::ADDR_W-1:0] paddr,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// error sources from the core
	input  wire logic                                soft_panic,
	input  wire logic                                loop_overrun,
	input  wire logic                                stack_overrun,
	input  wire logic [error_manager_pkg::PARITY_BITS-1:0] parity_error,
	input  wire logic [15:0]                         execute_pc,
	input  wire logic                                frame_restart,
	// status
	output logic                                     error_flag,
	output logic                                     irq
);
	import error_manager_pkg::*;

	// ===========================================================
	// state
	logic [PARITY_BITS-1:0] parity_mask_q;
	logic                   soft_mask_q;
	logic                   watchdog_report_mask;
	logic                   stack_mask_q;
	logic                   loop_mask_q;
	logic                   clear_q;
	logic                   clear_prev_q;
	logic                   flag_q;
	logic [15:0]            code_q;
	logic [15:0]            fault_pc_q;
	logic [RELOAD_W-1:0]    reload_q;
	logic [DIV_W-1:0]       divider_q;
	logic [IRQ_BITS-1:0]    irq_status_q;
	logic [IRQ_BITS-1:0]    irq_mask_q;
	logic [31:0]            prdata_q;
	logic                   slverr_q;

	logic [15:0]            raw_err;
	logic [15:0]            mask_vec;
	logic [15:0]            reported;
	logic                   any_err;
	logic                   clr_edge;
	logic                   setup;
	logic                   wr_access;
	logic [31:0]            rd_mux;
	logic                   mapped;
	logic [IRQ_BITS-1:0]    irq_set;

	watchdog_if wdi ();

	// ===========================================================
	// address decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign pready    = 1'b1;
	assign prdata    = prdata_q;
	assign pslverr   = psel && penable && slverr_q;

	// ===========================================================
	// error collection
	always_comb begin
		raw_err = {soft_panic, loop_overrun, stack_overrun, wdi.expire,
			parity_error};
		mask_vec = {soft_mask_q, loop_mask_q, stack_mask_q,
			watchdog_report_mask, parity_mask_q};
		reported = raw_err & ~mask_vec;
		any_err = |reported;
		clr_edge = clear_q && !clear_prev_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (any_err) begin
			flag_q <= 1'b1;
		end else if (clr_edge) begin
			flag_q <= 1'b0;
		end
	end

	// first error is held; a clear with a new error recaptures it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q <= RST_REG;
		end else if (any_err && (!flag_q || clr_edge)) begin
			code_q <= reported;
		end else if (clr_edge) begin
			code_q <= RST_REG;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_pc_q <= RST_REG;
		end else if (soft_panic) begin
			fault_pc_q <= execute_pc;
		end else if (wr_access && hit(paddr, IDX_FAULT_PC)) begin
			fault_pc_q <= pwdata[15:0];
		end
	end

	// ===========================================================
	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_mask_q        <= RST_PARITY_MASK;
			soft_mask_q          <= 1'b0;
			watchdog_report_mask <= 1'b0;
			stack_mask_q         <= 1'b0;
			loop_mask_q          <= 1'b0;
			clear_q              <= 1'b0;
			reload_q             <= '0;
			divider_q            <= '0;
			irq_mask_q           <= '0;
		end else if (wr_access) begin
			if (hit(paddr, IDX_PARITY_MASK))
				parity_mask_q <= pwdata[PARITY_BITS-1:0];
			if (hit(paddr, IDX_SOFT_MASK))
				soft_mask_q <= pwdata[0];
			if (hit(paddr, IDX_WD_MASK))
				watchdog_report_mask <= pwdata[0];
			if (hit(paddr, IDX_STACK_MASK))
				stack_mask_q <= pwdata[0];
			if (hit(paddr, IDX_LOOP_MASK))
				loop_mask_q <= pwdata[0];
			if (hit(paddr, IDX_CLEAR))
				clear_q <= pwdata[0];
			if (hit(paddr, IDX_WD_RELOAD))
				reload_q <= pwdata[RELOAD_W-1:0];
			if (hit(paddr, IDX_WD_DIVIDER))
				divider_q <= pwdata[DIV_W-1:0];
			if (hit(paddr, IDX_IRQ_MASK))
				irq_mask_q <= pwdata[IRQ_BITS-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_prev_q <= 1'b0;
		end else begin
			clear_prev_q <= clear_q;
		end
	end

	// ===========================================================
	// interrupt status, write one to clear, set wins
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_BIT_ERROR] = any_err && !flag_q;
		irq_set[IRQ_BIT_WD] = wdi.expire;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
		end else if (wr_access && hit(paddr, IDX_IRQ_STATUS)) begin
			irq_status_q <= (irq_status_q & ~pwdata[IRQ_BITS-1:0]) |
				irq_set;
		end else begin
			irq_status_q <= irq_status_q | irq_set;
		end
	end

	assign irq        = |(irq_status_q & ~irq_mask_q);
	assign error_flag = flag_q;

	// ===========================================================
	// read path, captured in the setup cycle
	always_comb begin
		rd_mux = '0;
		mapped = 1'b1;
		case (paddr[ADDR_W-1:2])
			IDX_CLEAR:        rd_mux[0] = clear_q;
			IDX_PARITY_MASK:  rd_mux[PARITY_BITS-1:0] = parity_mask_q;
			IDX_SOFT_MASK:    rd_mux[0] = soft_mask_q;
			IDX_WD_MASK:      rd_mux[0] = watchdog_report_mask;
			IDX_STACK_MASK:   rd_mux[0] = stack_mask_q;
			IDX_LOOP_MASK:    rd_mux[0] = loop_mask_q;
			IDX_SUMMARY_FLAG: rd_mux[0] = flag_q;
			IDX_SOURCE_CODE:  rd_mux[15:0] = code_q;
			IDX_FAULT_PC:     rd_mux[15:0] = fault_pc_q;
			IDX_WD_RELOAD:    rd_mux[RELOAD_W-1:0] = reload_q;
			IDX_WD_DIVIDER:   rd_mux[DIV_W-1:0] = divider_q;
			IDX_IRQ_STATUS:   rd_mux[IRQ_BITS-1:0] = irq_status_q;
			IDX_IRQ_MASK:     rd_mux[IRQ_BITS-1:0] = irq_mask_q;
			default:          mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			slverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			slverr_q <= !mapped;
		end
	end

	// ===========================================================
	// watchdog
	assign wdi.watchdog_reload_value   = reload_q;
	assign wdi.watchdog_divider_select = divider_q;
	assign wdi.frame_restart           = frame_restart;

	watchdog_counter #(
		.STEP_BASE (STEP_BASE)
	) i_watchdog_counter (
		.pclk    (pclk),
		.presetn (presetn),
		.wd      (wdi.wd)
	);

	// ===========================================================
	// checks
	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		any_err |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("unmasked error did not set the flag");

	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(flag_q && !clr_edge) |=> flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag fell without a clear edge");

	property p_code_hold;
		@(posedge pclk) disable iff (!presetn)
		(flag_q && !clr_edge) |=> $stable(code_q);
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("source code changed after first error");

	property p_clear_edge;
		@(posedge pclk) disable iff (!presetn)
		(clr_edge && !any_err) |=> !flag_q && code_q == 16'h0000;
	endproperty
	a_clear_edge: assert property (p_clear_edge)
		else $error("clear edge did not clear flag and code");

	property p_level_no_clear;
		@(posedge pclk) disable iff (!presetn)
		(clear_q && clear_prev_q && flag_q) |=> flag_q;
	endproperty
	a_level_no_clear: assert property (p_level_no_clear)
		else $error("held clear level cleared the flag");

	property p_wd_masked;
		@(posedge pclk) disable iff (!presetn)
		(wdi.expire && watchdog_report_mask && !flag_q && !soft_panic &&
			!loop_overrun && !stack_overrun && parity_error == '0)
			|=> !flag_q;
	endproperty
	a_wd_masked: assert property (p_wd_masked)
		else $error("masked watchdog expiry set the flag");

	property p_pc_capture;
		@(posedge pclk) disable iff (!presetn)
		soft_panic |=> fault_pc_q == $past(execute_pc);
	endproperty
	a_pc_capture: assert property (p_pc_capture)
		else $error("execute count not captured on software panic");

	property p_first_code;
		@(posedge pclk) disable iff (!presetn)
		(any_err && !flag_q) |=> code_q == $past({
			soft_panic && !soft_mask_q, loop_overrun && !loop_mask_q,
			stack_overrun && !stack_mask_q,
			wdi.expire && !watchdog_report_mask,
			parity_error & ~parity_mask_q});
	endproperty
	a_first_code: assert property (p_first_code)
		else $error("first error code does not match the sources");
endmodule

// ---- error_manager_bench.sv ----
// self-checking bench for the error manager
`timescale 1ns/1ps
module error_manager_bench;
	import error_manager_pkg::*;
	localparam int unsigned STEP = 4;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, slverr, soft_panic;
	logic              loop_overrun, stack_overrun, frame_restart;
	logic [11:0]       parity_error;
	logic [15:0]       execute_pc, pc;
	logic              error_flag, irq;
	int                fails = 0;
	int                compares = 0;
	int                cycles = 0;
	error_manager #(.STEP_BASE(STEP)) i_error_manager (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .soft_panic(soft_panic),
		.loop_overrun(loop_overrun), .stack_overrun(stack_overrun),
		.parity_error(parity_error), .execute_pc(execute_pc),
		.frame_restart(frame_restart), .error_flag(error_flag), .irq(irq));
	error_core_model i_error_core_model (.pclk(pclk),
		.soft_panic(soft_panic), .loop_overrun(loop_overrun),
		.stack_overrun(stack_overrun), .parity_error(parity_error),
		.execute_pc(execute_pc), .frame_restart(frame_restart));
	// ===========================================================
	// shared helpers
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] idx,
			input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= {idx, 2'b00};
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic clear_errors();
		apb(1'b1, IDX_CLEAR, 32'h0000_0000);
		apb(1'b1, IDX_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge pclk);
	endtask
	// ===========================================================
	// scenarios
	task automatic t_registers();
		logic [15:0] ix[9] = '{IDX_SUMMARY_FLAG, IDX_SOURCE_CODE,
			IDX_FAULT_PC, IDX_WD_RELOAD, IDX_WD_DIVIDER, IDX_SOFT_MASK,
			IDX_WD_MASK, IDX_STACK_MASK, IDX_LOOP_MASK};
		foreach (ix[i]) rdchk(ix[i], 32'h0000_0000);
		rdchk(IDX_PARITY_MASK, 32'h0000_0003);
		check(slverr, 1'b0);
		apb(1'b0, 16'h0000, 32'h0000_0000);
		check(slverr, 1'b1);
		apb(1'b1, IDX_WD_RELOAD, 32'hFFFF_FFFF);
		rdchk(IDX_WD_RELOAD, 32'h0000_1FFF);
		apb(1'b1, IDX_SUMMARY_FLAG, 32'h0000_0001);
		rdchk(IDX_SUMMARY_FLAG, 32'h0000_0000);
		apb(1'b1, IDX_FAULT_PC, 32'h0000_1234);
		rdchk(IDX_FAULT_PC, 32'h0000_1234);
	endtask
	task automatic t_first_error();
		i_error_core_model.fire(16'h4000, pc);
		@(posedge pclk);
		check(error_flag, 1'b1);
		i_error_core_model.fire(16'h2000, pc);
		rdchk(IDX_SOURCE_CODE, 32'h0000_4000);
		check(error_flag, 1'b1);
		clear_errors();
		rdchk(IDX_SUMMARY_FLAG, 32'h0000_0000);
		rdchk(IDX_SOURCE_CODE, 32'h0000_0000);
		i_error_core_model.fire(16'h2000, pc);
		apb(1'b1, IDX_CLEAR, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check(error_flag, 1'b1);
		rdchk(IDX_SOURCE_CODE, 32'h0000_2000);
		clear_errors();
	endtask
	task automatic t_code_bits();
		logic [15:0] mk[4] = '{IDX_PARITY_MASK, IDX_SOFT_MASK,
			IDX_STACK_MASK, IDX_LOOP_MASK};
		i_error_core_model.fire(16'h0003, pc);
		repeat (2) @(posedge pclk);
		check(error_flag, 1'b0);
		apb(1'b1, IDX_PARITY_MASK, 32'h0000_0000);
		for (int i = 0; i < 16; i++) begin
			if (i != BIT_WD) begin
				i_error_core_model.fire(16'h0001 << i, pc);
				rdchk(IDX_SOURCE_CODE, 32'h0000_0001 << i);
				clear_errors();
			end
		end
		foreach (mk[i]) apb(1'b1, mk[i], 32'h0000_0FFF);
		i_error_core_model.fire(16'hEFFF, pc);
		repeat (2) @(posedge pclk);
		check(error_flag, 1'b0);
		foreach (mk[i]) apb(1'b1, mk[i], 32'h0000_0000);
	endtask
	task automatic t_fault_pc();
		i_error_core_model.fire(16'h8000, pc);
		rdchk(IDX_FAULT_PC, {16'h0000, pc});
		clear_errors();
	endtask
	task automatic wd_time(input int rl, input int sel, input int lim,
			output int n);
		apb(1'b1, IDX_WD_RELOAD, rl);
		apb(1'b1, IDX_WD_DIVIDER, sel);
		clear_errors();
		i_error_core_model.restart();
		n = 0;
		while (error_flag !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic t_watchdog();
		int n, t;
		for (int s = 0; s < 14; s++) begin
			t = STEP << ((s > 11) ? 11 : s);
			wd_time(1, s, 20000, n);
			check(n >= t - 1 && n <= t + 4, 1'b1);
		end
		wd_time(5, 1, 20000, n);
		check(n >= 39 && n <= 44, 1'b1);
		rdchk(IDX_SOURCE_CODE, 32'h0000_1000);
		wd_time(5, 0, 15, n);
		repeat (6) begin
			i_error_core_model.restart();
			repeat (14) @(posedge pclk);
		end
		check(error_flag, 1'b0);
		apb(1'b1, IDX_WD_MASK, 32'h0000_0001);
		apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0003);
		wd_time(1, 0, 20, n);
		check(error_flag, 1'b0);
		rdchk(IDX_IRQ_STATUS, 32'h0000_0002);
		apb(1'b1, IDX_WD_MASK, 32'h0000_0000);
	endtask
	task automatic t_irq();
		apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0003);
		@(posedge pclk);
		check(irq, 1'b0);
		i_error_core_model.fire(16'h2000, pc);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1);
		apb(1'b1, IDX_IRQ_MASK, 32'h0000_0001);
		@(posedge pclk);
		check(irq, 1'b0);
		apb(1'b1, IDX_IRQ_MASK, 32'h0000_0000);
		@(posedge pclk);
		check(irq, 1'b1);
		apb(1'b1, IDX_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		check(irq, 1'b0);
	endtask
	// ===========================================================
	// clock, timeout and main sequence
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0000_0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_registers();
		t_first_error();
		t_code_bits();
		t_fault_pc();
		t_watchdog();
		t_irq();
		print_verdict();
	end
endmodule

// ---- error_manager_pkg.sv ----
// register map, field layout and reset values of the error manager
package error_manager_pkg;
	// ===========================================================
	// register indices (byte address = 4 * index)
	localparam int          ADDR_W            = 18;
	localparam logic [15:0] IDX_CLEAR         = 16'hF421;
	localparam logic [15:0] IDX_PARITY_MASK   = 16'hF422;
	localparam logic [15:0] IDX_SOFT_MASK     = 16'hF423;
	localparam logic [15:0] IDX_WD_MASK       = 16'hF424;
	localparam logic [15:0] IDX_STACK_MASK    = 16'hF425;
	localparam logic [15:0] IDX_LOOP_MASK     = 16'hF426;
	localparam logic [15:0] IDX_SUMMARY_FLAG  = 16'hF427;
	localparam logic [15:0] IDX_SOURCE_CODE   = 16'hF428;
	localparam logic [15:0] IDX_FAULT_PC      = 16'hF432;
	localparam logic [15:0] IDX_WD_RELOAD     = 16'hF443;
	localparam logic [15:0] IDX_WD_DIVIDER    = 16'hF444;
	localparam logic [15:0] IDX_IRQ_STATUS    = 16'hF470;
	localparam logic [15:0] IDX_IRQ_MASK      = 16'hF471;
	// ===========================================================
	// reset values
	localparam logic [11:0] RST_PARITY_MASK   = 12'h003;
	localparam logic [15:0] RST_REG           = 16'h0000;
	// ===========================================================
	// source code bit positions
	localparam int          BIT_SOFT          = 15;
	localparam int          BIT_LOOP          = 14;
	localparam int          BIT_STACK         = 13;
	localparam int          BIT_WD            = 12;
	localparam int          PARITY_BITS       = 12;
	// interrupt status bits
	localparam int          IRQ_BIT_ERROR     = 0;
	localparam int          IRQ_BIT_WD        = 1;
	localparam int          IRQ_BITS          = 2;
	// ===========================================================
	// watchdog
	localparam int          RELOAD_W          = 13;
	localparam int          DIV_W             = 4;
	localparam int          PRE_W             = 17;
	localparam logic [3:0]  DIV_SEL_MAX       = 4'hB;
	localparam int unsigned STEP_BASE_CYCLES  = 64;
endpackage

// ---- watchdog_counter.sv ----
// prescaled down-counting watchdog
`timescale 1ns/1ps
module watchdog_counter #(
	parameter int unsigned STEP_BASE = error_manager_pkg::STEP_BASE_CYCLES
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// manager side
	watchdog_if.wd    wd
);
	import error_manager_pkg::*;

	logic [PRE_W-1:0]    pre_q;
	logic [RELOAD_W-1:0] cnt_q;
	logic                expire_q;
	logic [DIV_W-1:0]    sel_eff;
	logic [PRE_W-1:0]    limit;
	logic                step;

	// ===========================================================
	// prescaler
	always_comb begin
		sel_eff = (wd.watchdog_divider_select > DIV_SEL_MAX) ?
			DIV_SEL_MAX : wd.watchdog_divider_select;
		limit = PRE_W'((STEP_BASE << sel_eff) - 1);
		// a lowered divider steps at once instead of waiting for a wrap
		step = (pre_q >= limit);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= '0;
		end else if (wd.frame_restart || step) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// ===========================================================
	// down counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (wd.frame_restart) begin
			cnt_q <= wd.watchdog_reload_value;
		end else if (step && cnt_q != '0) begin
			cnt_q <= cnt_q - RELOAD_W'(1);
		end
	end

	// one pulse when the count steps onto zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expire_q <= 1'b0;
		end else begin
			expire_q <= !wd.frame_restart && step &&
				cnt_q == RELOAD_W'(1);
		end
	end

	assign wd.expire = expire_q;

	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		wd.frame_restart |=> cnt_q == $past(wd.watchdog_reload_value);
	endproperty
	a_reload: assert property (p_reload)
		else $error("watchdog not reloaded on frame restart");

	property p_decrement;
		@(posedge pclk) disable iff (!presetn)
		(step && !wd.frame_restart && cnt_q != '0)
			|=> cnt_q == $past(cnt_q) - RELOAD_W'(1);
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("watchdog did not step down by one");

	property p_expire;
		@(posedge pclk) disable iff (!presetn)
		wd.expire |-> cnt_q == '0 && $past(cnt_q) == RELOAD_W'(1);
	endproperty
	a_expire: assert property (p_expire)
		else $error("watchdog expiry without reaching zero");

	// holds for any step base of four clocks or more
	property p_step_spacing;
		@(posedge pclk) disable iff (!presetn)
		(step && wd.watchdog_divider_select == 4'h0 && !wd.frame_restart)
			|=> !step [*3];
	endproperty
	a_step_spacing: assert property (p_step_spacing)
		else $error("watchdog steps closer than the prescale interval");
endmodule

// ---- watchdog_if.sv ----
// carrier between the error manager and its watchdog counter
`timescale 1ns/1ps
interface watchdog_if;
	import error_manager_pkg::*;
	logic [RELOAD_W-1:0] watchdog_reload_value;
	logic [DIV_W-1:0]    watchdog_divider_select;
	logic                frame_restart;
	logic                expire;
	modport mgr (output watchdog_reload_value, watchdog_divider_select,
		frame_restart, input expire);
	modport wd (input watchdog_reload_value, watchdog_divider_select,
		frame_restart, output expire);
endinterface
